// ### core/pwbt_pkg.sv
// constants for the program word bridge and address trace block
package pwbt_pkg;
  localparam logic [15:0] PWBT_ADDR_UPPER_BYTE = 16'hFFF2;
  localparam logic [15:0] PWBT_ADDR_LOWER_HALF = 16'hFFF3;
  localparam logic [15:0] PWBT_ADDR_FULL       = 16'hFFF4;
  localparam int          PWBT_WORD_W          = 24;
  localparam int          PWBT_HALF_W          = 16;
  localparam int          PWBT_BYTE_W          = 8;
  localparam int          PWBT_ADDR_W          = 16;
  localparam logic [23:0] PWBT_BRIDGE_RESET    = 24'h000000;
  localparam logic [15:0] PWBT_ADDR_RESET      = 16'h0000;
  typedef enum logic [2:0] {
    PWBT_BUS_IDLE  = 3'h1,
    PWBT_BUS_EXT   = 3'h2,
    PWBT_BUS_TRACE = 3'h4
  } pwbt_bus_e;
endpackage : pwbt_pkg

// ### core/pwbt_strobe_gen.sv
// half-cycle active-low strobe generator for new bus addresses
`timescale 1ns/1ps
module pwbt_strobe_gen
  import pwbt_pkg::*;
(
  input  wire logic sys_clk,   // core clock
  input  wire logic resetn,    // async reset, active low
  input  wire logic new_addr,  // registered: new address this cycle
  output logic      strobe_n   // low during low phase of sys_clk while new_addr is set
);
  // low only in second half of a cycle carrying a new address
  always_comb begin
    strobe_n = ~(resetn & new_addr & ~sys_clk);
  end

  // sampled at the rising edge, so this sees the low phase just ending
  a_strobe_new_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    strobe_n == !new_addr)
    else $error("strobe does not follow new address");
  a_strobe_reset_off: assert property (@(posedge sys_clk)
    !resetn |-> strobe_n)
    else $error("strobe active in reset");
endmodule : pwbt_strobe_gen

// ### core/pwbt_bridge.sv
// program word bridge register and program address trace output
// Overview of operation
// - bridge seen as 24-bit and two 16-bit locations
// - high half upper eight bits reserved
// - 24-bit location moves whole program word
// - low half is bits 15:0, high 23:16
// - half accesses are plain data I/O
// - high half read zeroes destination upper bits
// - trace enable puts fetch addresses on bus
// - external accesses win over trace cycles
// - no strobes or chip select in trace
// - trace strobe pulses on every new address
// - trace shows fetches, not executed flow
// - trace strobe active low, half cycle
// - trace strobe deasserted during reset
// - 16-to-24 extends, 24-to-16 truncates
`timescale 1ns/1ps
module pwbt_bridge
  import pwbt_pkg::*;
(
  input  wire logic        sys_clk,              // core clock 125 MHz
  input  wire logic        resetn,               // async reset, active low
  input  wire logic        io_wr,                // data-space I/O write strobe
  input  wire logic        io_rd,                // data-space I/O read strobe
  input  wire logic [15:0] io_addr,              // data-space I/O address
  input  wire logic [23:0] io_wdata,             // write data, 16-bit sources in low bits
  output logic      [23:0] io_rdata,             // registered read data
  output logic             io_hit,               // address is a bridge location
  input  wire logic        pmem_to_bridge,       // program word moved into full location
  input  wire logic [23:0] pmem_rdata,           // program word being moved in
  output logic      [23:0] pmem_wdata,           // bridge content toward program memory
  input  wire logic        trace_enable_bit,     // trace bit of operating_mode_reg
  input  wire logic        fetch_valid,          // internal fetch or program move this cycle
  input  wire logic [15:0] fetch_addr,           // its program address
  input  wire logic        ext_req,              // real external access this cycle
  input  wire logic        ext_wr,               // external access is a write
  input  wire logic [15:0] ext_addr,             // external access address
  output logic      [15:0] external_address_lines, // address pins
  output logic             memory_chip_select_n, // external memory select
  output logic             ext_rd_n,             // external read strobe
  output logic             ext_wr_n,             // external write strobe
  output logic             trace_strobe_n        // new-address strobe, active low
);
  logic [23:0] program_word_bridge_reg;
  pwbt_bus_e   bus_state;
  pwbt_bus_e   next_bus_state;
  logic        new_addr;
  logic [PWBT_HALF_W-1:0] low_half;
  logic [PWBT_BYTE_W-1:0] high_byte;

  function automatic logic is_loc(input logic [15:0] a, input logic [15:0] loc);
    is_loc = (a == loc);
  endfunction : is_loc

  assign io_hit = is_loc(io_addr, PWBT_ADDR_FULL) | is_loc(io_addr, PWBT_ADDR_LOWER_HALF)
                | is_loc(io_addr, PWBT_ADDR_UPPER_BYTE);
  assign pmem_wdata = program_word_bridge_reg;
  assign low_half   = program_word_bridge_reg[PWBT_HALF_W-1:0];
  assign high_byte  = program_word_bridge_reg[PWBT_WORD_W-1:PWBT_HALF_W];

  // bridge register writes; program move takes priority as it is the 24-bit path
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      program_word_bridge_reg <= PWBT_BRIDGE_RESET;
    end else if (pmem_to_bridge) begin
      program_word_bridge_reg <= pmem_rdata;
    end else if (io_wr && is_loc(io_addr, PWBT_ADDR_FULL)) begin
      program_word_bridge_reg <= io_wdata;
    end else if (io_wr && is_loc(io_addr, PWBT_ADDR_LOWER_HALF)) begin
      program_word_bridge_reg[PWBT_HALF_W-1:0] <= io_wdata[PWBT_HALF_W-1:0];
    end else if (io_wr && is_loc(io_addr, PWBT_ADDR_UPPER_BYTE)) begin
      program_word_bridge_reg[PWBT_WORD_W-1:PWBT_HALF_W] <= io_wdata[PWBT_BYTE_W-1:0];
    end
  end

  // read data; high half returns byte zero-extended over all 24 bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_rdata <= PWBT_BRIDGE_RESET;
    end else if (io_rd) begin
      if (is_loc(io_addr, PWBT_ADDR_FULL)) begin
        io_rdata <= program_word_bridge_reg;
      end else if (is_loc(io_addr, PWBT_ADDR_LOWER_HALF)) begin
        io_rdata <= PWBT_WORD_W'(low_half);
      end else if (is_loc(io_addr, PWBT_ADDR_UPPER_BYTE)) begin
        io_rdata <= PWBT_WORD_W'(high_byte);
      end else begin
        io_rdata <= PWBT_BRIDGE_RESET;
      end
    end
  end

  // bus arbitration: external first, trace only on spare cycles
  always_comb begin
    if (ext_req) begin
      next_bus_state = PWBT_BUS_EXT;
    end else if (trace_enable_bit && fetch_valid) begin
      next_bus_state = PWBT_BUS_TRACE;
    end else begin
      next_bus_state = PWBT_BUS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state <= PWBT_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // address pins hold their last value while idle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      external_address_lines <= PWBT_ADDR_RESET;
      new_addr               <= 1'b0;
    end else begin
      case (next_bus_state)
        PWBT_BUS_EXT: begin
          external_address_lines <= ext_addr;
          new_addr               <= 1'b1;
        end
        PWBT_BUS_TRACE: begin
          external_address_lines <= fetch_addr;
          new_addr               <= 1'b1;
        end
        default: begin
          new_addr <= 1'b0;
        end
      endcase
    end
  end

  // select and strobes only on genuine external cycles
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      memory_chip_select_n <= 1'b1;
      ext_rd_n             <= 1'b1;
      ext_wr_n             <= 1'b1;
    end else begin
      memory_chip_select_n <= (next_bus_state != PWBT_BUS_EXT);
      ext_rd_n             <= !((next_bus_state == PWBT_BUS_EXT) && !ext_wr);
      ext_wr_n             <= !((next_bus_state == PWBT_BUS_EXT) && ext_wr);
    end
  end

  pwbt_strobe_gen u_strobe (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .new_addr (new_addr),
    .strobe_n (trace_strobe_n)
  );

  sequence s_trace_req;
    !ext_req && trace_enable_bit && fetch_valid;
  endsequence

  sequence s_trace_out;
    memory_chip_select_n && ext_rd_n && ext_wr_n && new_addr;
  endsequence

  sequence s_ext_ctl;
    !memory_chip_select_n && (ext_rd_n != ext_wr_n) && new_addr;
  endsequence

  a_trace_address_out: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_trace_req |=> external_address_lines == $past(fetch_addr))
    else $error("trace address not driven");
  a_trace_quiet_ctl: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_trace_req |=> s_trace_out)
    else $error("control asserted in trace cycle");
  a_ext_wins_bus: assert property (@(posedge sys_clk) disable iff (!resetn)
    ext_req |=> !memory_chip_select_n && external_address_lines == $past(ext_addr))
    else $error("external access lost bus");
  a_new_addr_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ext_req || (trace_enable_bit && fetch_valid)) |=> new_addr)
    else $error("no strobe for new address");
  a_no_trace_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!ext_req && !trace_enable_bit) |=> !new_addr)
    else $error("trace while disabled");
  a_full_move_in: assert property (@(posedge sys_clk) disable iff (!resetn)
    pmem_to_bridge |=> pmem_wdata == $past(pmem_rdata))
    else $error("24-bit move lost bits");
  a_high_read_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (io_rd && io_addr == PWBT_ADDR_UPPER_BYTE) |=> io_rdata[23:8] == 16'h0000
      && io_rdata[7:0] == $past(program_word_bridge_reg[23:16]))
    else $error("high half read not zero-extended");
  a_low_write_keeps: assert property (@(posedge sys_clk) disable iff (!resetn)
    (io_wr && !pmem_to_bridge && io_addr == PWBT_ADDR_LOWER_HALF) |=>
      program_word_bridge_reg[23:16] == $past(program_word_bridge_reg[23:16])
      && program_word_bridge_reg[15:0] == $past(io_wdata[15:0]))
    else $error("low half write wrong");
  a_high_write_byte: assert property (@(posedge sys_clk) disable iff (!resetn)
    (io_wr && !pmem_to_bridge && io_addr == PWBT_ADDR_UPPER_BYTE) |=>
      program_word_bridge_reg == {$past(io_wdata[7:0]), $past(program_word_bridge_reg[15:0])})
    else $error("high half write wrong");
  a_trace_cycle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_state == PWBT_BUS_TRACE |-> s_trace_out)
    else $error("trace cycle drives control");
  a_ext_cycle_ctl: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_state == PWBT_BUS_EXT |-> s_ext_ctl)
    else $error("external cycle control wrong");
  a_idle_addr_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_state == PWBT_BUS_IDLE |-> $stable(external_address_lines) && !new_addr)
    else $error("address moved without strobe");
  a_move_wins_io: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pmem_to_bridge && io_wr) |=> program_word_bridge_reg == $past(pmem_rdata))
    else $error("io write beat program move");
  a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    (io_rd && !io_hit) |=> io_rdata == PWBT_BRIDGE_RESET)
    else $error("unmapped read not zero");
  a_full_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    (io_rd && io_addr == PWBT_ADDR_FULL) |=> io_rdata == $past(program_word_bridge_reg))
    else $error("full read wrong");
  a_low_read_trunc: assert property (@(posedge sys_clk) disable iff (!resetn)
    (io_rd && io_addr == PWBT_ADDR_LOWER_HALF) |=> io_rdata == {8'h00, $past(program_word_bridge_reg[15:0])})
    else $error("low half read not truncated");
  a_rdata_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    !io_rd |=> $stable(io_rdata))
    else $error("read data changed without read");
endmodule : pwbt_bridge

// ### test/pwbt_trace_capture.sv
// trace capture model that samples the address pins on the strobe
`timescale 1ns/1ps
module pwbt_trace_capture (
  input  wire logic        trace_strobe_n,         // new-address strobe
  input  wire logic [15:0] external_address_lines, // address pins
  input  wire logic        memory_chip_select_n,   // external select
  output logic      [15:0] cap_addr,               // last sampled address
  output logic             cap_ext,                // last sample was external
  output int               cap_count               // strobes seen
);
  initial begin
    cap_addr = 16'h0000;
    cap_ext = 1'b0;
    cap_count = 0;
  end
  // logs every strobed address, fetch or external, never rebuilds program flow
  always @(negedge trace_strobe_n) begin
    cap_addr <= external_address_lines;
    cap_ext <= ~memory_chip_select_n;
    cap_count <= cap_count + 1;
  end
endmodule : pwbt_trace_capture

// ### test/pwbt_bridge_test.sv
// self-checking bench for the bridge register and address trace
`timescale 1ns/1ps
module pwbt_bridge_test;
  import pwbt_pkg::*;
  logic        sys_clk, resetn, io_wr, io_rd, io_hit, pmem_to_bridge, trace_enable_bit, fetch_valid;
  logic        ext_req, ext_wr, memory_chip_select_n, ext_rd_n, ext_wr_n, trace_strobe_n, cap_ext, nw, xe, xw;
  logic [15:0] io_addr, fetch_addr, ext_addr, external_address_lines, cap_addr, ea;
  logic [23:0] io_wdata, pmem_rdata, io_rdata, pmem_wdata, w;
  int          cap_count, mismatches, compares, i, n;
  pwbt_bridge u_dut (.sys_clk, .resetn, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_hit,
    .pmem_to_bridge, .pmem_rdata, .pmem_wdata, .trace_enable_bit, .fetch_valid, .fetch_addr, .ext_req,
    .ext_wr, .ext_addr, .external_address_lines, .memory_chip_select_n, .ext_rd_n, .ext_wr_n, .trace_strobe_n);
  pwbt_trace_capture u_cap (.trace_strobe_n, .external_address_lines, .memory_chip_select_n, .cap_addr,
    .cap_ext, .cap_count);
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // waits a falling edge first so two calls never share one time step
  task automatic io(input logic wr, input logic [15:0] a, input logic [23:0] d);
    @(negedge sys_clk);
    io_wr = wr;
    io_rd = !wr;
    io_addr = a;
    io_wdata = d;
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io
  // external access outranks a traced fetch; idle keeps the old address
  function automatic logic [15:0] next_addr(input logic [15:0] prev);
    if (ext_req) return ext_addr;
    if (trace_enable_bit && fetch_valid) return fetch_addr;
    return prev;
  endfunction : next_addr
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
  initial begin
    {io_wr, io_rd, pmem_to_bridge, trace_enable_bit, fetch_valid, ext_req, ext_wr, resetn} = '0;
    {io_addr, fetch_addr, ext_addr, io_wdata, pmem_rdata} = '0;
    mismatches = 0;
    compares = 0;
    n = $urandom(32'hBDFFBEF7);
    repeat (5) @(negedge sys_clk);
    chk("strobe in reset", 24'h1, trace_strobe_n);
    resetn = 1'b1;
    for (i = 0; i < 20; i++) begin
      w = 24'($urandom);
      io(1'b1, PWBT_ADDR_FULL, w);
      io(1'b0, PWBT_ADDR_LOWER_HALF, 24'h0);
      chk("lower half", {8'h00, w[15:0]}, io_rdata);
      chk("mapped hit", 24'h1, io_hit);
      io(1'b0, PWBT_ADDR_UPPER_BYTE, 24'h0);
      chk("upper byte", {16'h0000, w[23:16]}, io_rdata);
      io(1'b1, PWBT_ADDR_UPPER_BYTE, ~w);
      io(1'b1, PWBT_ADDR_LOWER_HALF, w ^ 24'h00FFFF);
      io(1'b0, PWBT_ADDR_FULL, 24'h0);
      chk("full word", {~w[7:0], ~w[15:0]}, io_rdata);
      chk("program view", {~w[7:0], ~w[15:0]}, pmem_wdata);
    end
    $display("test half and full access done");
    // program move and io write in the same cycle: the move must win
    @(negedge sys_clk);
    pmem_rdata = 24'($urandom);
    pmem_to_bridge = 1'b1;
    io_wr = 1'b1;
    io_addr = PWBT_ADDR_FULL;
    io_wdata = ~pmem_rdata;
    @(negedge sys_clk);
    pmem_to_bridge = 1'b0;
    io_wr = 1'b0;
    io(1'b0, PWBT_ADDR_FULL, 24'h0);
    chk("program word in", pmem_rdata, io_rdata);
    chk("program word out", pmem_rdata, pmem_wdata);
    io(1'b0, 16'hFFF5, 24'h0);
    chk("unmapped read", 24'h0, io_rdata);
    chk("unmapped hit", 24'h0, io_hit);
    $display("test program move and unmapped done");
    ea = external_address_lines;
    for (i = 0; i < 60; i++) begin
      @(negedge sys_clk);
      n = cap_count;
      ext_req = ($urandom % 3) == 0;
      ext_wr = 1'($urandom);
      fetch_valid = 1'($urandom);
      trace_enable_bit = (i % 8) != 7;
      fetch_addr = 16'($urandom);
      ext_addr = 16'($urandom);
      ea = next_addr(ea);
      nw = ext_req || (trace_enable_bit && fetch_valid);
      xe = ext_req;
      xw = ext_wr;
      @(negedge sys_clk);
      ext_req = 1'b0;
      fetch_valid = 1'b0;
      #1;
      chk("address", ea, external_address_lines);
      chk("select", {!xe, !(xe && !xw), !(xe && xw)}, {memory_chip_select_n, ext_rd_n, ext_wr_n});
      chk("strobe", !nw, trace_strobe_n);
      chk("captures", n + nw, cap_count);
      if (nw) chk("captured address", ea, cap_addr);
      if (nw) chk("captured kind", xe, cap_ext);
      if (nw && !cap_ext) chk("trace cycle strobes", 24'h7, {memory_chip_select_n, ext_rd_n, ext_wr_n});
      // strobe must be back up in the high phase that follows
      @(posedge sys_clk);
      #1;
      chk("strobe released", 24'h1, trace_strobe_n);
    end
    $display("test address trace done");
    // fetch offered while reset is applied mid-run: nothing may reach the pins
    @(negedge sys_clk);
    n = cap_count;
    trace_enable_bit = 1'b1;
    fetch_valid = 1'b1;
    fetch_addr = 16'($urandom);
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("strobe in reset", 24'h1, trace_strobe_n);
    chk("captures in reset", n, cap_count);
    chk("controls in reset", 24'h7, {memory_chip_select_n, ext_rd_n, ext_wr_n});
    chk("bridge in reset", PWBT_BRIDGE_RESET, pmem_wdata);
    fetch_valid = 1'b0;
    resetn = 1'b1;
    io(1'b0, PWBT_ADDR_FULL, 24'h0);
    chk("bridge after reset", PWBT_BRIDGE_RESET, io_rdata);
    chk("address after reset", PWBT_ADDR_RESET, external_address_lines);
    $display("test reset mid-run done");
    end_sim();
  end
endmodule : pwbt_bridge_test
